//--- twdg_pkg.sv
// constants, register map and types of the two-stage boot watchdog
package twdg_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SEC_NS        = 1_000_000_000;
	localparam int unsigned TICK_CYC_DEF  = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned PULSE_NS      = 1000;
	localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_BOOTTIME = 8'h04;
	localparam logic [7:0] OFS_CMD      = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	// ==========================================================
	// control fields
	localparam int unsigned CTL_BOOTSTART = 0;
	localparam int unsigned CTL_BOOT_EN   = 1;
	localparam int unsigned CTL_BOOT_PWR  = 2;
	localparam int unsigned CTL_EVT_PIN   = 3;
	localparam int unsigned CTL_RST_ACT   = 4;
	localparam int unsigned CTL_DLY_SEL   = 6;
	localparam int unsigned CTL_EVT_SEL   = 9;
	localparam int unsigned CTL_RST_SEL   = 12;
	localparam logic [14:0] CTRL_RST      = 15'h0002;
	localparam logic [7:0]  BOOTTIME_RST  = 8'd20;
	// command bits, status-bit layout of interrupt registers
	localparam int unsigned CMD_REFRESH = 0;
	localparam int unsigned CMD_START   = 1;
	localparam int unsigned CMD_STOP    = 2;
	localparam int unsigned IRQ_EVT  = 0;
	localparam int unsigned IRQ_RST  = 1;
	localparam int unsigned IRQ_BOOT = 2;
	// reset actions
	localparam logic [1:0] RACT_NONE = 2'd0;
	localparam logic [1:0] RACT_RST  = 2'd1;
	localparam logic [1:0] RACT_PIN  = 2'd2;
	localparam logic [1:0] RACT_BOTH = 2'd3;
	// runtime watchdog states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_DELAY = 5'b00010,
		ST_EVENT = 5'b00100,
		ST_RESET = 5'b01000,
		ST_DONE  = 5'b10000
	} twdg_state_e;
endpackage

//--- twdg_top.sv
// two-stage runtime watchdog plus boot-phase watchdog with an AHB-Lite register slave
// Functional notes
// - start-on-boot runs watchdog after self-test
// - one-time startup delay before first countdown
// - event timeout expiry triggers event action
// - event action: nothing or alert pin
// - reset timeout counts only after event expiry
// - reset action: none, reset, pin, both
// - boot watchdog supervises until OS hand-off
// - boot time in seconds, default twenty
// - boot expiry: system reset or power cycle
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module twdg_top #(
	parameter int unsigned TICK_CYC = twdg_pkg::TICK_CYC_DEF
) (
	input  wire logic        ref_clk_i,             // 125 MHz clock
	input  wire logic        rst_n_i,               // async reset, active low
	input  wire logic        hsel_i,                // slave select
	input  wire logic [7:0]  haddr_i,               // byte address
	input  wire logic [1:0]  htrans_i,              // transfer type
	input  wire logic        hwrite_i,              // write
	input  wire logic [2:0]  hsize_i,               // size, word only
	input  wire logic [31:0] hwdata_i,              // write data
	input  wire logic        hready_i,              // bus ready
	output logic             hreadyout_o,           // slave ready
	output logic             hresp_o,               // always okay
	output logic [31:0]      hrdata_o,              // read data
	input  wire logic        selftest_done_i,       // firmware self-test finished pin
	input  wire logic        os_handoff_i,          // os boot hand-off pin
	output logic             watchdog_alert_pin_o,  // alert output
	output logic             sys_reset_o,           // system reset request
	output logic             power_cycle_o,         // power cycle request
	output logic             irq_o                  // level interrupt
);
	// ==========================================================
	// helpers
	// selection code to seconds; codes four and above act as five minutes
	function automatic logic [8:0] sel_secs(input logic [2:0] sel);
		unique case (sel)
			3'd0:    sel_secs = 9'd1;
			3'd1:    sel_secs = 9'd10;
			3'd2:    sel_secs = 9'd30;
			3'd3:    sel_secs = 9'd60;
			default: sel_secs = 9'd300;
		endcase
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [1:0] done_sync_ff, hand_sync_ff;
	logic       done_d_ff;
	logic       done_rise;
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			done_sync_ff <= 2'b00;
			hand_sync_ff <= 2'b00;
			done_d_ff    <= 1'b0;
		end
		else
		begin
			done_sync_ff <= {done_sync_ff[0], selftest_done_i};
			hand_sync_ff <= {hand_sync_ff[0], os_handoff_i};
			done_d_ff    <= done_sync_ff[1];
		end
	end
	assign done_rise = done_sync_ff[1] & ~done_d_ff;

	// ==========================================================
	// one-second enable; free running, so a timeout may end up to one second early
	logic [31:0] div_ff, nxt_div;
	logic        tick;
	always_comb
	begin
		tick    = (div_ff == TICK_CYC - 1);
		nxt_div = tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) div_ff <= 32'h0000_0000;
		else          div_ff <= nxt_div;
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic        ap_wr_ff, ap_rd_ff;
	logic [7:0]  ap_addr_ff;
	logic        ap_take;
	logic [14:0] ctrl_ff, nxt_ctrl;
	logic [7:0]  boot_time_ff, nxt_boot_time;
	logic [2:0]  irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask;
	logic [31:0] nxt_rdata;
	logic        wr_cmd, refresh, sw_start, sw_stop;
	logic [2:0]  irq_set;
	twdg_pkg::twdg_state_e st_ff, nxt_st;
	logic [8:0]  cnt_ff, nxt_cnt;
	logic [8:0]  boot_cnt_ff, nxt_boot_cnt;
	logic        boot_run_ff, nxt_boot_run, boot_hit_ff, nxt_boot_hit;
	logic        dly_used_ff, nxt_dly_used;

	assign ap_take     = hsel_i & hready_i & htrans_i[1];
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign wr_cmd      = ap_wr_ff & (ap_addr_ff == twdg_pkg::OFS_CMD);
	assign refresh     = wr_cmd & hwdata_i[twdg_pkg::CMD_REFRESH];
	assign sw_start    = wr_cmd & hwdata_i[twdg_pkg::CMD_START];
	assign sw_stop     = wr_cmd & hwdata_i[twdg_pkg::CMD_STOP];

	// register writes; hardware set of a status bit wins over a write-one clear
	always_comb
	begin
		nxt_ctrl      = ctrl_ff;
		nxt_boot_time = boot_time_ff;
		nxt_irq_mask  = irq_mask_ff;
		nxt_irq_stat  = irq_stat_ff;
		if (ap_wr_ff)
		begin
			unique case (ap_addr_ff)
				twdg_pkg::OFS_CTRL:     nxt_ctrl = hwdata_i[14:0];
				twdg_pkg::OFS_BOOTTIME: nxt_boot_time = hwdata_i[7:0];
				twdg_pkg::OFS_IRQ_MASK: nxt_irq_mask = hwdata_i[2:0];
				twdg_pkg::OFS_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~hwdata_i[2:0];
				default:                nxt_ctrl = ctrl_ff;
			endcase
		end
		nxt_irq_stat = nxt_irq_stat | irq_set;
	end

	// read data prepared in the address phase
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (ap_take && !hwrite_i)
		begin
			unique case (haddr_i)
				twdg_pkg::OFS_CTRL:     nxt_rdata = {17'h0_0000, ctrl_ff};
				twdg_pkg::OFS_BOOTTIME: nxt_rdata = {24'h00_0000, boot_time_ff};
				twdg_pkg::OFS_STATUS:   nxt_rdata = {6'h00, boot_cnt_ff, cnt_ff,
					watchdog_alert_pin_o, boot_hit_ff, boot_run_ff, st_ff};
				twdg_pkg::OFS_IRQ_STAT: nxt_rdata = {29'h0000_0000, irq_stat_ff};
				twdg_pkg::OFS_IRQ_MASK: nxt_rdata = {29'h0000_0000, irq_mask_ff};
				default:                nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ap_wr_ff     <= 1'b0;
			ap_rd_ff     <= 1'b0;
			ap_addr_ff   <= 8'h00;
			hrdata_o     <= 32'h0000_0000;
			ctrl_ff      <= twdg_pkg::CTRL_RST;
			boot_time_ff <= twdg_pkg::BOOTTIME_RST;
			irq_stat_ff  <= 3'b000;
			irq_mask_ff  <= 3'b000;
		end
		else
		begin
			ap_wr_ff     <= ap_take & hwrite_i;
			ap_rd_ff     <= ap_take & ~hwrite_i;
			ap_addr_ff   <= haddr_i;
			hrdata_o     <= nxt_rdata;
			ctrl_ff      <= nxt_ctrl;
			boot_time_ff <= nxt_boot_time;
			irq_stat_ff  <= nxt_irq_stat;
			irq_mask_ff  <= nxt_irq_mask;
		end
	end
	assign irq_o = |(irq_stat_ff & irq_mask_ff);

	// ==========================================================
	// runtime watchdog
	logic [8:0] evt_secs, rst_secs, dly_secs;
	logic [1:0] rst_act;
	logic       expire, evt_exp, rst_exp;
	logic       pin_ff, nxt_pin, rst_req, pwr_req;
	assign dly_secs = sel_secs(ctrl_ff[twdg_pkg::CTL_DLY_SEL +: 3]);
	assign evt_secs = sel_secs(ctrl_ff[twdg_pkg::CTL_EVT_SEL +: 3]);
	assign rst_secs = sel_secs(ctrl_ff[twdg_pkg::CTL_RST_SEL +: 3]);
	assign rst_act  = ctrl_ff[twdg_pkg::CTL_RST_ACT +: 2];
	assign expire   = tick & (cnt_ff == 9'd1);
	assign evt_exp  = (st_ff == twdg_pkg::ST_EVENT) & expire & ~refresh & ~sw_stop;
	assign rst_exp  = (st_ff == twdg_pkg::ST_RESET) & expire & ~refresh & ~sw_stop;

	// state, countdown and alert pin; refresh during the delay phase is ignored
	always_comb
	begin
		nxt_st       = st_ff;
		nxt_cnt      = cnt_ff;
		nxt_dly_used = dly_used_ff;
		nxt_pin      = pin_ff;
		rst_req      = 1'b0;
		if (tick && cnt_ff > 9'd1)
			nxt_cnt = cnt_ff - 9'd1;
		unique case (st_ff)
			twdg_pkg::ST_IDLE, twdg_pkg::ST_DONE:
			begin
				if ((done_rise && ctrl_ff[twdg_pkg::CTL_BOOTSTART]) || sw_start)
				begin
					nxt_pin = 1'b0;
					if (!dly_used_ff)
					begin
						nxt_st       = twdg_pkg::ST_DELAY;
						nxt_cnt      = dly_secs;
						nxt_dly_used = 1'b1;
					end
					else
					begin
						nxt_st  = twdg_pkg::ST_EVENT;
						nxt_cnt = evt_secs;
					end
				end
			end
			twdg_pkg::ST_DELAY:
			begin
				if (expire)
				begin
					nxt_st  = twdg_pkg::ST_EVENT;
					nxt_cnt = evt_secs;
				end
			end
			twdg_pkg::ST_EVENT, twdg_pkg::ST_RESET:
			begin
				if (refresh)
				begin
					nxt_st  = twdg_pkg::ST_EVENT;
					nxt_cnt = evt_secs;
					nxt_pin = 1'b0;
				end
				else if (evt_exp)
				begin
					nxt_st  = twdg_pkg::ST_RESET;
					nxt_cnt = rst_secs;
					if (ctrl_ff[twdg_pkg::CTL_EVT_PIN])
						nxt_pin = 1'b1;
				end
				else if (rst_exp)
				begin
					nxt_st  = twdg_pkg::ST_DONE;
					rst_req = (rst_act == twdg_pkg::RACT_RST) || (rst_act == twdg_pkg::RACT_BOTH);
					if ((rst_act == twdg_pkg::RACT_PIN) || (rst_act == twdg_pkg::RACT_BOTH))
						nxt_pin = 1'b1;
				end
			end
		endcase
		if (sw_stop)
		begin
			nxt_st  = twdg_pkg::ST_IDLE;
			nxt_pin = 1'b0;
		end
	end

	// ==========================================================
	// boot-phase watchdog: armed from reset, ends at hand-off
	logic boot_exp;
	assign boot_exp = boot_run_ff & tick & ~hand_sync_ff[1] & ((boot_cnt_ff + 9'd1) >= {1'b0, boot_time_ff});
	always_comb
	begin
		nxt_boot_run = boot_run_ff;
		nxt_boot_cnt = boot_cnt_ff;
		nxt_boot_hit = boot_hit_ff;
		pwr_req      = 1'b0;
		if (!ctrl_ff[twdg_pkg::CTL_BOOT_EN] || hand_sync_ff[1])
			nxt_boot_run = 1'b0;
		else if (boot_exp)
		begin
			nxt_boot_run = 1'b0;
			nxt_boot_hit = 1'b1;
			pwr_req      = ctrl_ff[twdg_pkg::CTL_BOOT_PWR];
		end
		else if (boot_run_ff && tick)
			nxt_boot_cnt = boot_cnt_ff + 9'd1;
	end
	assign irq_set = {boot_exp, rst_exp, evt_exp};

	// ==========================================================
	// request pulses of fixed length
	logic [7:0] rpulse_ff, nxt_rpulse, ppulse_ff, nxt_ppulse;
	always_comb
	begin
		nxt_rpulse = (rpulse_ff != 8'd0) ? rpulse_ff - 8'd1 : 8'd0;
		nxt_ppulse = (ppulse_ff != 8'd0) ? ppulse_ff - 8'd1 : 8'd0;
		if (rst_req || (boot_exp && !ctrl_ff[twdg_pkg::CTL_BOOT_PWR]))
			nxt_rpulse = 8'(twdg_pkg::PULSE_CYC);
		if (pwr_req)
			nxt_ppulse = 8'(twdg_pkg::PULSE_CYC);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff       <= twdg_pkg::ST_IDLE;
			cnt_ff      <= 9'd0;
			dly_used_ff <= 1'b0;
			pin_ff      <= 1'b0;
			boot_run_ff <= 1'b1;
			boot_cnt_ff <= 9'd0;
			boot_hit_ff <= 1'b0;
			rpulse_ff   <= 8'd0;
			ppulse_ff   <= 8'd0;
			sys_reset_o   <= 1'b0;
			power_cycle_o <= 1'b0;
		end
		else
		begin
			st_ff       <= nxt_st;
			cnt_ff      <= nxt_cnt;
			dly_used_ff <= nxt_dly_used;
			pin_ff      <= nxt_pin;
			boot_run_ff <= nxt_boot_run;
			boot_cnt_ff <= nxt_boot_cnt;
			boot_hit_ff <= nxt_boot_hit;
			rpulse_ff   <= nxt_rpulse;
			ppulse_ff   <= nxt_ppulse;
			sys_reset_o   <= (nxt_rpulse != 8'd0);
			power_cycle_o <= (nxt_ppulse != 8'd0);
		end
	end
	assign watchdog_alert_pin_o = pin_ff;

	// ==========================================================
	// checks
	sequence s_evt_expiry;
		evt_exp;
	endsequence
	sequence s_enter_reset_wait;
		(st_ff == twdg_pkg::ST_RESET) && (cnt_ff == rst_secs);
	endsequence
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_BOOT_START: assert property (st_ff == twdg_pkg::ST_IDLE && done_rise && !sw_stop
		&& ctrl_ff[twdg_pkg::CTL_BOOTSTART] |=> st_ff != twdg_pkg::ST_IDLE)
		else $error("watchdog did not start after self-test");
	AST_STAY_STOPPED: assert property (st_ff == twdg_pkg::ST_IDLE && !sw_start
		&& !ctrl_ff[twdg_pkg::CTL_BOOTSTART] |=> st_ff == twdg_pkg::ST_IDLE)
		else $error("watchdog left idle without start");
	AST_DELAY_ONCE: assert property ($rose(st_ff == twdg_pkg::ST_DELAY) |-> !$past(dly_used_ff))
		else $error("startup delay applied twice");
	AST_DELAY_END: assert property (st_ff == twdg_pkg::ST_DELAY && expire && !sw_stop
		|=> st_ff == twdg_pkg::ST_EVENT && cnt_ff == evt_secs)
		else $error("delay did not hand over to event countdown");
	AST_EVT_EXPIRE: assert property (s_evt_expiry |=> s_enter_reset_wait ##0 irq_stat_ff[0])
		else $error("event expiry did not start reset countdown");
	AST_EVT_PIN: assert property (s_evt_expiry ##0 ctrl_ff[twdg_pkg::CTL_EVT_PIN]
		|=> watchdog_alert_pin_o)
		else $error("event action did not raise alert pin");
	AST_RESET_ONLY_AFTER_EVT: assert property ($rose(st_ff == twdg_pkg::ST_RESET)
		|-> $past(evt_exp))
		else $error("reset countdown began without event expiry");
	AST_RST_ACTION: assert property (rst_exp && rst_act[0] |=> sys_reset_o [*8])
		else $error("reset action missing reset pulse");
	AST_RST_NONE: assert property (rst_exp && rst_act == twdg_pkg::RACT_NONE && !pin_ff
		|=> !watchdog_alert_pin_o && st_ff == twdg_pkg::ST_DONE)
		else $error("reset action none changed the pin");
	AST_BOOT_HANDOFF: assert property (hand_sync_ff[1] |=> !boot_run_ff && !boot_hit_ff[*1])
		else $error("boot watchdog ran past hand-off");
	AST_BOOT_TIME: assert property (boot_run_ff && tick && !hand_sync_ff[1]
		&& ctrl_ff[twdg_pkg::CTL_BOOT_EN] && boot_cnt_ff + 9'd1 >= {1'b0, boot_time_ff}
		|=> boot_hit_ff && irq_stat_ff[2])
		else $error("boot time exceeded without recovery");
	AST_BOOT_PWR: assert property (boot_exp && ctrl_ff[twdg_pkg::CTL_BOOT_EN]
		&& !hand_sync_ff[1] && ctrl_ff[twdg_pkg::CTL_BOOT_PWR] |=> power_cycle_o && !$rose(sys_reset_o))
		else $error("boot recovery chose the wrong action");
	AST_REFRESH: assert property ((st_ff == twdg_pkg::ST_RESET) && refresh && !sw_stop
		|=> st_ff == twdg_pkg::ST_EVENT && cnt_ff == evt_secs && !watchdog_alert_pin_o)
		else $error("refresh did not cancel reset countdown");
endmodule
`default_nettype wire

//--- twdg_host_model.sv
// host firmware and reset/power circuit model facing the watchdog pins
`timescale 1ns/1ps
`default_nettype none
module twdg_host_model (
	input  wire logic clk_i,         // system clock
	input  wire logic st_req_i,      // self-test is allowed to finish
	input  wire logic ho_req_i,      // os hand-off is allowed to happen
	input  wire logic sys_reset_i,   // reset request from the watchdog
	input  wire logic power_cycle_i, // power cycle request from the watchdog
	output logic      st_done_o,     // self-test finished pin
	output logic      handoff_o,     // hand-off reached pin
	output int        rst_cnt_o,     // reset pulses seen
	output int        pwr_cnt_o      // power cycles seen
);
	logic rst_q;
	logic pwr_q;
	// ==========================================================
	// host pins and recovery counters
	initial
	begin
		rst_q = 1'b0;
		pwr_q = 1'b0;
		st_done_o = 1'b0;
		handoff_o = 1'b0;
		rst_cnt_o = 0;
		pwr_cnt_o = 0;
	end
	// a reset or power cycle restarts the host, so self-test drops and is redone
	always @(posedge clk_i)
	begin
		rst_q <= sys_reset_i;
		pwr_q <= power_cycle_i;
		if (sys_reset_i && !rst_q)
			rst_cnt_o <= rst_cnt_o + 1;
		if (power_cycle_i && !pwr_q)
			pwr_cnt_o <= pwr_cnt_o + 1;
		st_done_o <= st_req_i && !sys_reset_i && !power_cycle_i;
		handoff_o <= ho_req_i;
	end
endmodule
`default_nettype wire

//--- two_stage_boot_watchdog_tb_top.sv
// self-checking bench for the two-stage boot watchdog
`timescale 1ns/1ps
`default_nettype none
module two_stage_boot_watchdog_tb_top;
	localparam int TK = 20; // cycles per second, keeps runs short
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic        st_req    = 1'b0;
	logic        ho_req    = 1'b0;
	logic [7:0]  haddr     = 8'h00;
	logic [1:0]  htrans    = 2'h0;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hready, hresp, alert, sreset, pcycle, irq, st_done, handoff;
	int          rcnt, pcnt, t0, w, bt, ep, r0, c;
	int          cyc = 0;
	int          num_errors = 0;
	int          total_checks = 0;

	twdg_top #(.TICK_CYC(TK)) uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .selftest_done_i(st_done),
		.os_handoff_i(handoff), .watchdog_alert_pin_o(alert), .sys_reset_o(sreset),
		.power_cycle_o(pcycle), .irq_o(irq));
	twdg_host_model host (.clk_i(ref_clk_i), .st_req_i(st_req), .ho_req_i(ho_req),
		.sys_reset_i(sreset), .power_cycle_i(pcycle), .st_done_o(st_done),
		.handoff_o(handoff), .rst_cnt_o(rcnt), .pwr_cnt_o(pcnt));
	// ==========================================================
	// clock and cycle counter
	initial
	begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) cyc <= cyc + 1;
	// ==========================================================
	// compare, bus and closing tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_win(input string nm, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// polls the sticky status, bounded by lim cycles from t0
	task automatic wait_irq(input int b, input int lim);
		do bus(1'b0, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0000);
		while (rd[b] !== 1'b1 && cyc - t0 < lim);
		w = cyc - t0;
	endtask
	function automatic logic [31:0] cfg(input int bs, be, bp, e, ra, ds, es);
		return 32'(bs) | 32'(be) << twdg_pkg::CTL_BOOT_EN
			| 32'(bp) << twdg_pkg::CTL_BOOT_PWR | 32'(e) << twdg_pkg::CTL_EVT_PIN
			| 32'(ra) << twdg_pkg::CTL_RST_ACT | 32'(ds) << twdg_pkg::CTL_DLY_SEL
			| 32'(es) << twdg_pkg::CTL_EVT_SEL;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, far beyond the few thousand cycles the tests need
	initial
	begin
		repeat (30000) @(posedge ref_clk_i);
		num_errors++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		w = $urandom(36);
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t0 = cyc;
		// boot supervision expires into a power cycle
		bt = 3 + $urandom % 3;
		bus(1'b1, twdg_pkg::OFS_BOOTTIME, 32'(bt));
		bus(1'b1, twdg_pkg::OFS_CTRL, cfg(0, 1, 1, 0, 0, 0, 0));
		while (pcnt == 0 && cyc - t0 < 200) @(posedge ref_clk_i);
		chk_win("boot expiry", (bt - 1) * TK, bt * TK + 4, cyc - t0);
		repeat (bt * TK) @(posedge ref_clk_i);
		chk("power cycles", 1, pcnt);
		chk("resets", 0, rcnt);
		bus(1'b0, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0000);
		chk("boot irq", 32'h0000_0004, rd);
		bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
		chk("boot flags", 32'h0000_0002, 32'(rd[6:5]));
		// second reset with hand-off reached: reset values, no recovery
		rst_n_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		ho_req <= 1'b1;
		rst_n_i <= 1'b1;
		bus(1'b0, twdg_pkg::OFS_CTRL, 32'h0000_0000);
		chk("ctrl reset", 32'h0000_0002, rd);
		chk("hresp okay", 0, hresp);
		bus(1'b0, twdg_pkg::OFS_BOOTTIME, 32'h0000_0000);
		chk("boottime reset", 32'd20, rd);
		bus(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		bus(1'b0, twdg_pkg::OFS_CMD, 32'h0000_0000);
		chk("cmd read", 32'h0000_0000, rd);
		repeat (450) @(posedge ref_clk_i);
		bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0001, 32'(rd[7:0]));
		chk("power cycles", 1, pcnt);
		chk("resets", 0, rcnt);
		// self-test done without start-on-boot keeps it stopped
		st_req <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
		chk("state", 32'(twdg_pkg::ST_IDLE), 32'(rd[4:0]));
		st_req <= 1'b0;
		c = cfg(1, 0, 0, 0, 0, 1, 0);
		bus(1'b1, twdg_pkg::OFS_CTRL, c);
		bus(1'b0, twdg_pkg::OFS_CTRL, 32'h0000_0000);
		chk("ctrl", c, rd);
		st_req <= 1'b1;
		t0 = cyc;
		repeat (10) @(posedge ref_clk_i);
		bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
		chk("state", 32'(twdg_pkg::ST_DELAY), 32'(rd[4:0]));
		wait_irq(0, 400);
		chk_win("first event", 9 * TK, 11 * TK + 30, w);
		wait_irq(1, 300);
		bus(1'b1, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0007);
		bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0002);
		t0 = cyc;
		wait_irq(0, 100);
		chk_win("later event", 0, TK + 10, w);
		wait_irq(1, 300);
		// every reset action, random event action, masked and unmasked irq
		for (int a = 0; a < 4; a++)
		begin
			ep = $urandom % 2;
			r0 = rcnt;
			bus(1'b1, twdg_pkg::OFS_CTRL, cfg(0, 0, 0, ep, a, 0, 1));
			bus(1'b1, twdg_pkg::OFS_IRQ_MASK, 32'(a % 2));
			bus(1'b1, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0007);
			chk("irq cleared", 0, irq);
			bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0002);
			bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0001);
			bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
			chk("refreshed", 32'h0000_0004, 32'({rd[7], rd[4:0]}));
			t0 = cyc;
			wait_irq(0, 260);
			chk("alert after event", 32'(ep), alert);
			chk("irq level", 32'(a % 2), irq);
			bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
			chk("state", 32'(twdg_pkg::ST_RESET), 32'(rd[4:0]));
			t0 = cyc;
			wait_irq(1, 60);
			chk("alert after reset", 32'(ep | a / 2), alert);
			bus(1'b1, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0001);
			// the clear lands on the edge that ends the task, so look once it has settled
			@(negedge ref_clk_i);
			chk("irq after clear", 0, irq);
			repeat (130) @(posedge ref_clk_i);
			chk("resets", 32'(r0 + a % 2), rcnt);
		end
		// steady refreshes hold off the event stage
		bus(1'b1, twdg_pkg::OFS_CTRL, cfg(0, 0, 0, 1, 0, 0, 1));
		bus(1'b1, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0007);
		bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0002);
		repeat (5)
		begin
			repeat (100) @(posedge ref_clk_i);
			bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0001);
		end
		bus(1'b0, twdg_pkg::OFS_IRQ_STAT, 32'h0000_0000);
		chk("no event", 32'h0000_0000, rd);
		chk("alert idle", 0, alert);
		bus(1'b1, twdg_pkg::OFS_CMD, 32'h0000_0004);
		bus(1'b0, twdg_pkg::OFS_STATUS, 32'h0000_0000);
		chk("stopped", 32'(twdg_pkg::ST_IDLE), 32'(rd[4:0]));
		end_of_test();
	end
endmodule
`default_nettype wire
